// [rtl/qrb_regs.svh]
// Overview of operation
// R01: Read address captured on positive input edge
// R02: Accesses start on positive input clock edge
// R03: One write word per input edge
// R04: One read word per output edge
// R05: Output registers; single-clock mode uses input pair
// R06: Two 18-bit words per location, burst two
// R07: Read and write ports run independently
// R08: Separate select per port for depth expansion
// R09: All inputs captured in input registers
// R10: Array write completes self-timed after capture
// R11: Separate one-way read and write data buses
// R12: Controller multiplexes read/write address each cycle
// R13: Write address on negative edge; deselect ignores
// R14: Low write select on positive edge starts write
// R15: Read select starts read; deselect tristates after
// R16: Byte selects gate bits 8:0 and 17:9
// R17: Array 2^18 locations, burst index picks word
// R18: Fixed latency from read request to data
`ifndef QRB_REGS_SVH
`define QRB_REGS_SVH

// =====================================================================
// Geometry
`define QRB_AW 18
`define QRB_DW 18
`define QRB_DEPTH (1 << 18)
`define QRB_LO_MSB 8
`define QRB_LO_LSB 0
`define QRB_HI_MSB 17
`define QRB_HI_LSB 9

// =====================================================================
// Read latency in clock cycles and return buffer depth in entries
`define QRB_RD_LAT 3
`define QRB_BUF_DEPTH 2

// =====================================================================
// Reset values
`define QRB_SEL_RST 1'b1
`define QRB_OE_N_RST 1'b1
`define QRB_KPOS_RST 1'b0

`endif

// [rtl/qrb_pkg.sv]
`include "qrb_regs.svh"

package qrb_pkg;
  typedef logic [`QRB_AW-1:0] qrb_addr_t;
  typedef logic [`QRB_DW-1:0] qrb_word_t;
  typedef logic [1:0] qrb_bytes_t;
  typedef logic [2*`QRB_DW-1:0] qrb_pair_t;
  typedef logic [1:0] qrb_resv_t;
endpackage

// [rtl/qrb_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface qrb_if;
  import qrb_pkg::*;
  logic k_pos;
  logic c_pos;
  qrb_addr_t addr;
  logic read_port_select_n;
  logic write_port_select_n;
  qrb_word_t wdata;
  logic byte_write_sel_low_n;
  logic byte_write_sel_high_n;
  qrb_word_t q;
  logic q_oe_n;

  modport dev (
    input k_pos, c_pos, addr, read_port_select_n, write_port_select_n, wdata,
    input byte_write_sel_low_n, byte_write_sel_high_n,
    output q, q_oe_n
  );
  modport ctrl (
    output k_pos, c_pos, addr, read_port_select_n, write_port_select_n, wdata,
    output byte_write_sel_low_n, byte_write_sel_high_n,
    input q, q_oe_n
  );
endinterface
`default_nettype wire

// [rtl/qrb_sram_dev.sv]
`timescale 1ns/1ns
`default_nettype none
`include "qrb_regs.svh"
module qrb_sram_dev import qrb_pkg::*; (
  input wire logic clk,              // System clock
  input wire logic rst,              // Async reset, active high
  qrb_if.dev link,                   // Memory pins
  input wire logic single_clk_mode,  // Strap: outputs follow the input clock pair
  output logic wr_done,              // Pulse when a burst lands in the array
  output logic rd_busy               // Read data is being driven
);

  // =====================================================================
  // Byte-merge helper
  function automatic qrb_word_t merge(input qrb_word_t old_w, input qrb_word_t new_w,
                                      input logic lo_n, input logic hi_n);
    qrb_word_t r;
    r = old_w;
    if (!lo_n) begin
      r[`QRB_LO_MSB:`QRB_LO_LSB] = new_w[`QRB_LO_MSB:`QRB_LO_LSB];
    end
    if (!hi_n) begin
      r[`QRB_HI_MSB:`QRB_HI_LSB] = new_w[`QRB_HI_MSB:`QRB_HI_LSB];
    end
    return r;
  endfunction

  // =====================================================================
  // Array, one bank per burst index
  // Not reset: a location reads as unknown until it is first written
  // Bank 0 holds the first word of every burst, bank 1 the second
  qrb_word_t mem0 [`QRB_DEPTH];  // see R06
  qrb_word_t mem1 [`QRB_DEPTH];  // see R17

  // =====================================================================
  // Edge decode
  // Each clk cycle stands for one edge of the pair; k_pos high marks K
  // In single-clock use the outputs follow the input pair instead
  logic mode_r;
  wire k_edge = link.k_pos;
  wire kn_edge = ~link.k_pos;
  wire out_pos = mode_r ? link.k_pos : link.c_pos;  // see R05
  wire rd_sel = k_edge & ~link.read_port_select_n;  // see R15
  wire wr_sel = k_edge & ~link.write_port_select_n;  // see R14

  // Strap is caught after reset release
  // A change of strap takes effect one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= 1'b0;
    end else begin
      mode_r <= single_clk_mode;
    end
  end

  // =====================================================================
  // Write input registers
  // The K cycle takes word0 and its gates; the K# cycle after it takes
  // the address, word1 and their gates and arms the commit
  logic wr_arm_r;
  logic wr_commit_r;
  qrb_addr_t wr_addr_r;
  qrb_word_t wd0_r;
  qrb_word_t wd1_r;
  logic be0_lo_r;
  logic be0_hi_r;
  logic be1_lo_r;
  logic be1_hi_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_arm_r <= 1'b0;
      wr_commit_r <= 1'b0;
      wr_addr_r <= '0;
      wd0_r <= '0;
      wd1_r <= '0;
      be0_lo_r <= 1'b1;
      be0_hi_r <= 1'b1;
      be1_lo_r <= 1'b1;
      be1_hi_r <= 1'b1;
    end else begin
      wr_commit_r <= 1'b0;
      if (k_edge) begin
        wr_arm_r <= wr_sel;  // see R02
        if (wr_sel) begin
          wd0_r <= link.wdata;  // see R03
          be0_lo_r <= link.byte_write_sel_low_n;  // see R16
          be0_hi_r <= link.byte_write_sel_high_n;
        end
      end else if (wr_arm_r) begin
        // Ignored entirely while the write port is deselected
        wr_addr_r <= link.addr;  // see R13
        wd1_r <= link.wdata;  // see R03
        be1_lo_r <= link.byte_write_sel_low_n;  // see R16
        be1_hi_r <= link.byte_write_sel_high_n;
        wr_commit_r <= 1'b1;  // see R09
        wr_arm_r <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Self-timed array write, one cycle after the burst is complete
  // Partial writes read the old word back and replace only gated bytes
  qrb_word_t wr_merged0;
  qrb_word_t wr_merged1;
  assign wr_merged0 = merge(mem0[wr_addr_r], wd0_r, be0_lo_r, be0_hi_r);  // see R16
  assign wr_merged1 = merge(mem1[wr_addr_r], wd1_r, be1_lo_r, be1_hi_r);

  always_ff @(posedge clk) begin
    if (wr_commit_r) begin  // see R10
      mem0[wr_addr_r] <= wr_merged0;
      mem1[wr_addr_r] <= wr_merged1;
    end
  end

  // =====================================================================
  // Read capture and array fetch
  // A read taken in the same K cycle as a write to the same location
  // fetches before that burst commits and so returns the old words
  logic rd_arm_r;
  logic rd_staged_r;
  qrb_addr_t rd_addr_r;
  qrb_word_t rw0_r;
  qrb_word_t rw1_r;
  wire rd_fetch = kn_edge & rd_arm_r;
  wire rd_take = out_pos & rd_staged_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_arm_r <= 1'b0;
      rd_addr_r <= '0;
    end else if (k_edge) begin
      rd_arm_r <= rd_sel;  // see R02
      if (rd_sel) begin
        rd_addr_r <= link.addr;  // see R01
      end
    end else begin
      rd_arm_r <= 1'b0;
    end
  end

  // Fetch on the negative edge; reads are untouched by writes in flight
  always_ff @(posedge clk) begin
    if (rd_fetch) begin  // see R07
      rw0_r <= mem0[rd_addr_r];
      rw1_r <= mem1[rd_addr_r];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_staged_r <= 1'b0;
    end else if (rd_fetch) begin
      rd_staged_r <= 1'b1;
    end else if (rd_take) begin
      rd_staged_r <= 1'b0;
    end
  end

  // =====================================================================
  // Output registers on the output clock pair
  // Word0 goes out after the positive output edge, word1 after the next;
  // the busy flag is its own flop so every output stays a clean register
  logic second_r;
  qrb_word_t q_r;
  logic q_oe_n_r;
  logic rd_busy_r;
  logic wr_done_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_r <= 1'b0;
      q_r <= '0;
      q_oe_n_r <= `QRB_OE_N_RST;
      rd_busy_r <= 1'b0;
    end else if (out_pos) begin
      second_r <= rd_staged_r;
      if (rd_staged_r) begin
        q_r <= rw0_r;  // see R04
        q_oe_n_r <= 1'b0;  // see R18
        rd_busy_r <= 1'b1;
      end else begin
        q_oe_n_r <= 1'b1;  // see R15
        rd_busy_r <= 1'b0;
      end
    end else if (second_r) begin
      q_r <= rw1_r;  // see R04
      second_r <= 1'b0;
    end
  end

  // One-cycle pulse in the cycle after the array has taken the burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_done_r <= 1'b0;
    end else begin
      wr_done_r <= wr_commit_r;
    end
  end

  // Dedicated output bus, no turnaround with the write data
  assign link.q = q_r;  // see R11
  assign link.q_oe_n = q_oe_n_r;
  assign wr_done = wr_done_r;
  assign rd_busy = rd_busy_r;

endmodule
`default_nettype wire

// [rtl/qrb_ctrl_host.sv]
`timescale 1ns/1ns
`default_nettype none
`include "qrb_regs.svh"
module qrb_ctrl_host import qrb_pkg::*; (
  input wire logic clk,              // System clock
  input wire logic rst,              // Async reset, active high
  qrb_if.ctrl link,                  // Memory pins
  input wire logic wr_valid,         // Write request
  output logic wr_ready,             // Write slot open this cycle
  input wire qrb_addr_t wr_addr,     // Write address
  input wire qrb_word_t wr_word0,    // First burst word
  input wire qrb_word_t wr_word1,    // Second burst word
  input wire qrb_bytes_t wr_bytes0,  // Byte enables for word0, high active
  input wire qrb_bytes_t wr_bytes1,  // Byte enables for word1, high active
  input wire logic rd_valid,         // Read request
  output logic rd_ready,             // Read slot open and buffer room
  input wire qrb_addr_t rd_addr,     // Read address
  output logic rsp_valid,            // Read burst available
  input wire logic rsp_ready,        // Consumer takes the burst
  output qrb_pair_t rsp_data         // {word1, word0}
);

  // =====================================================================
  // Phase and slot control
  logic k_pos_r;
  logic wr_ready_r;
  logic rd_ready_r;
  qrb_resv_t resv_r;
  wire load_slot = ~k_pos_r;
  wire wr_acc = wr_valid & wr_ready_r;
  wire rd_acc = rd_valid & rd_ready_r;
  wire pop = rsp_valid & rsp_ready;
  wire [2:0] resv_sum = {1'b0, resv_r} + {2'b00, rd_acc} - {2'b00, pop};
  wire qrb_resv_t resv_nxt = resv_sum[1:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      k_pos_r <= `QRB_KPOS_RST;
      wr_ready_r <= 1'b0;
      rd_ready_r <= 1'b0;
      resv_r <= '0;
    end else begin
      k_pos_r <= ~k_pos_r;
      wr_ready_r <= k_pos_r;  // see R02
      rd_ready_r <= k_pos_r & (resv_nxt < 2'(`QRB_BUF_DEPTH));
      resv_r <= resv_nxt;
    end
  end

  // =====================================================================
  // Pin drivers
  qrb_addr_t addr_r;
  logic rps_n_r;
  logic wps_n_r;
  qrb_word_t wdata_r;
  logic bws_lo_n_r;
  logic bws_hi_n_r;
  qrb_addr_t wa_h_r;
  qrb_word_t w1_h_r;
  qrb_bytes_t b1_h_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_r <= '0;
      rps_n_r <= `QRB_SEL_RST;
      wps_n_r <= `QRB_SEL_RST;
      wdata_r <= '0;
      bws_lo_n_r <= 1'b1;
      bws_hi_n_r <= 1'b1;
      wa_h_r <= '0;
      w1_h_r <= '0;
      b1_h_r <= '0;
    end else if (load_slot) begin
      rps_n_r <= ~rd_acc;  // see R08
      wps_n_r <= ~wr_acc;  // see R14
      if (rd_acc) begin
        addr_r <= rd_addr;  // see R12
      end
      wdata_r <= wr_word0;  // see R03
      bws_lo_n_r <= ~(wr_acc & wr_bytes0[0]);  // see R16
      bws_hi_n_r <= ~(wr_acc & wr_bytes0[1]);
      if (wr_acc) begin
        wa_h_r <= wr_addr;
        w1_h_r <= wr_word1;
        b1_h_r <= wr_bytes1;
      end
    end else begin
      rps_n_r <= 1'b1;
      wps_n_r <= 1'b1;
      addr_r <= wa_h_r;  // see R13
      wdata_r <= w1_h_r;
      bws_lo_n_r <= ~(~wps_n_r & b1_h_r[0]);
      bws_hi_n_r <= ~(~wps_n_r & b1_h_r[1]);
    end
  end

  assign link.k_pos = k_pos_r;
  assign link.c_pos = k_pos_r;
  assign link.addr = addr_r;
  assign link.read_port_select_n = rps_n_r;
  assign link.write_port_select_n = wps_n_r;
  assign link.wdata = wdata_r;
  assign link.byte_write_sel_low_n = bws_lo_n_r;
  assign link.byte_write_sel_high_n = bws_hi_n_r;

  // =====================================================================
  // Read return capture at fixed latency
  logic [`QRB_RD_LAT:0] iss_r;
  qrb_word_t cap0_r;
  wire push = iss_r[`QRB_RD_LAT];
  wire qrb_pair_t push_data = {link.q, cap0_r};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iss_r <= '0;
      cap0_r <= '0;
    end else begin
      iss_r <= {iss_r[`QRB_RD_LAT-1:0], k_pos_r & ~rps_n_r};  // see R18
      if (iss_r[`QRB_RD_LAT-1]) begin
        cap0_r <= link.q;  // see R06
      end
    end
  end

  // =====================================================================
  // Two-entry return buffer
  qrb_pair_t head_r;
  qrb_pair_t tail_r;
  logic head_v_r;
  logic tail_v_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_r <= '0;
      tail_r <= '0;
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
    end else if (pop) begin
      if (tail_v_r) begin
        head_r <= tail_r;
        tail_r <= push_data;
        tail_v_r <= push;
      end else begin
        head_r <= push_data;
        head_v_r <= push;
      end
    end else if (push) begin
      if (!head_v_r) begin
        head_r <= push_data;
        head_v_r <= 1'b1;
      end else begin
        tail_r <= push_data;
        tail_v_r <= 1'b1;
      end
    end
  end

  assign wr_ready = wr_ready_r;
  assign rd_ready = rd_ready_r;
  assign rsp_valid = head_v_r;
  assign rsp_data = head_r;

endmodule
`default_nettype wire

// [verif/qrb_link_props.sv]
`timescale 1ns/1ns
`default_nettype none
module qrb_link_props import qrb_pkg::*; (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic k_pos, // Input phase
  input wire logic c_pos, // Output phase
  input wire qrb_addr_t addr, // Address
  input wire logic read_port_select_n, // Read select
  input wire logic write_port_select_n, // Write select
  input wire qrb_word_t wdata, // Write word
  input wire logic byte_write_sel_low_n, // Low byte gate
  input wire logic byte_write_sel_high_n, // High byte gate
  input wire qrb_word_t q, // Read word
  input wire logic q_oe_n // Output enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // Burst shape
  sequence rd_burst;
    !q_oe_n ##1 !q_oe_n;
  endsequence
  a_kpos_toggle: assert property (!$past(rst) |-> k_pos != $past(k_pos))
    else $error("input phase stuck");
  a_cpos_follow: assert property (c_pos == k_pos)
    else $error("output phase differs");
  a_rsel_kcycle: assert property (!read_port_select_n |-> k_pos)
    else $error("read select off phase");
  a_wsel_kcycle: assert property (!write_port_select_n |-> k_pos)
    else $error("write select off phase");
  a_wsel_pair: assert property (!write_port_select_n |=> write_port_select_n && !k_pos)
    else $error("write pair broken");
  a_rd_latency: assert property (!read_port_select_n |-> ##3 rd_burst)
    else $error("read burst late");
  a_oe_cause: assert property (!q_oe_n |->
      !$past(read_port_select_n, 3) || !$past(read_port_select_n, 4))
    else $error("output driven without read");
  a_oe_word_pair: assert property (!q_oe_n && !k_pos |=> !q_oe_n)
    else $error("burst cut short");
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  import qrb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic single_clk_mode = 1'b0;
  logic wr_valid = 1'b0, rd_valid = 1'b0, rsp_ready = 1'b0, stall = 1'b0;
  qrb_addr_t wr_addr = '0, rd_addr = '0;
  qrb_pair_t wd = '0;
  logic [3:0] be = 4'h0;
  logic wr_ready, rd_ready, rsp_valid, wr_done, rd_busy;
  qrb_pair_t rsp_data, mem [qrb_addr_t], expq [$];
  qrb_addr_t pool [8];
  logic [31:0] lf = 32'h9dea;
  int miscompares = 0, compares = 0, wt = 0, rtk = 0, dn = 0, base = 0;
  always #4 clk = ~clk;
  qrb_if link ();
  qrb_sram_dev qrb_sram_dev_inst (.clk(clk), .rst(rst), .link(link),
    .single_clk_mode(single_clk_mode), .wr_done(wr_done), .rd_busy(rd_busy));
  qrb_ctrl_host qrb_ctrl_host_inst (.clk(clk), .rst(rst), .link(link),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_word0(wd[17:0]), .wr_word1(wd[35:18]), .wr_bytes0(be[1:0]),
    .wr_bytes1(be[3:2]), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data));
  qrb_link_props qrb_link_props_inst (.clk(clk), .rst(rst), .k_pos(link.k_pos),
    .c_pos(link.c_pos), .addr(link.addr), .read_port_select_n(link.read_port_select_n),
    .write_port_select_n(link.write_port_select_n), .wdata(link.wdata),
    .byte_write_sel_low_n(link.byte_write_sel_low_n),
    .byte_write_sel_high_n(link.byte_write_sel_high_n), .q(link.q), .q_oe_n(link.q_oe_n));
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic qrb_pair_t mrg(qrb_pair_t o, qrb_pair_t n, logic [3:0] b);
    qrb_pair_t m;
    m = {{9{b[3]}}, {9{b[2]}}, {9{b[1]}}, {9{b[0]}}};
    return (o & ~m) | (n & m);
  endfunction
  task automatic chk(logic [35:0] got, logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read expectation is taken before a same-edge write, which returns old data
  task automatic slot(bit dw, bit dr, qrb_addr_t wa, qrb_addr_t ra, qrb_pair_t d,
      logic [3:0] b, int lim);
    int n;
    bit tr, tw;
    n = 0;
    @(posedge clk);
    #1;
    wr_addr = wa;
    rd_addr = ra;
    wd = d;
    be = b;
    wr_valid = dw;
    rd_valid = dr;
    while ((wr_valid || rd_valid) && n < lim) begin
      tr = rd_valid && rd_ready === 1'b1;
      tw = wr_valid && wr_ready === 1'b1;
      @(posedge clk);
      n++;
      if (tr) begin
        expq.push_back(mem[rd_addr]);
        rtk++;
      end
      if (tw) begin
        mem[wr_addr] = mrg(mem[wr_addr], wd, be);
        wt++;
      end
      #1;
      if (tr)
        rd_valid = 1'b0;
      if (tw)
        wr_valid = 1'b0;
    end
    if (wr_valid || rd_valid) begin
      miscompares++;
      {wr_valid, rd_valid} = 2'b00;
    end
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (expq.size() > 0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
  endtask
  // ==========
  // Monitors
  always @(negedge clk) begin
    if (wr_done === 1'b1)
      dn++;
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
      chk(rsp_data, expq.size() > 0 ? expq.pop_front() : 36'hx);
    if (rst === 1'b0)
      chk(36'(rd_busy), 36'(!link.q_oe_n));
  end
  always @(posedge clk) begin
    #1;
    rsp_ready = !stall && rnd() % 4 != 0;
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  // ==========
  // Tests
  initial begin
    repeat (8) @(posedge clk);
    chk(36'(link.q_oe_n), 36'h1);
    #1 rst = 1'b0;
    foreach (pool[i]) pool[i] = i == 0 ? 18'h0 : i == 1 ? 18'h3ffff : 18'(rnd());
    foreach (pool[i]) slot(1'b1, 1'b0, pool[i], '0, 36'({rnd(), rnd()}), 4'hf, 20);
    $display("test fill done");
    foreach (pool[i]) slot(1'b0, 1'b1, '0, pool[i], '0, 4'h0, 20);
    drain();
    $display("test readback done");
    slot(1'b1, 1'b1, pool[2], pool[2], 36'({rnd(), rnd()}), 4'h5, 20);
    repeat (80) begin
      single_clk_mode = 1'(rnd());
      slot(1'(rnd()), 1'(rnd()), pool[rnd() % 8], pool[rnd() % 8],
        36'({rnd(), rnd()}), 4'(rnd()), 20);
    end
    drain();
    $display("test mixed done");
    stall = 1'b1;
    repeat (8) @(posedge clk);
    base = rtk;
    repeat (2) slot(1'b0, 1'b1, '0, pool[3], '0, 4'h0, 20);
    repeat (6) @(negedge clk) chk(36'(rd_ready), 36'h0);
    chk(36'(rtk - base), 36'h2);
    stall = 1'b0;
    drain();
    chk(36'(expq.size()), 36'h0);
    chk(36'(dn), 36'(wt));
    $display("test stall done");
    wrap_up();
  end
endmodule
`default_nettype wire
